// ==== hw/omd_params.svh ====
// Constants for the on-chip memory map decoder
//
// Notes on behaviour
// - Disabled user ROM occupies no addresses
// - User ROM disabled when its config bit clear
// - Separate 192-byte bootloader ROM beside user ROM
// - Normal modes never map the bootloader ROM
// - Test mode maps bootloader only after enable
// - Bootstrap maps bootloader at reset, vector BFFE
// - Secured part resets only single-chip or bootstrap
// - Single-chip vector from user ROM, no bus
// - Secure bootstrap wipes, verifies, then erases config
// - RAM starts at base of any 4K page
// - EEPROM selected for software program and erase
// - RAM page zero at reset; 64-cycle write window in normal modes
// - Internal hit returns internal data, ignores bus
`ifndef OMD_PARAMS_SVH
`define OMD_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define OMD_REG_CTRL 12'h000
`define OMD_REG_STAT 12'h004
`define OMD_CTRL_BOOT_BIT 4
`define OMD_CTRL_PAGE_MSB 3
`define OMD_STAT_MODE_MSB 1
`define OMD_STAT_SEC_BIT 2
`define OMD_STAT_WIN_BIT 3
`define OMD_STAT_ROM_BIT 4
`define OMD_STAT_DL_BIT 5

// ----------------------------------------------------------------
// Mode codes, mode pin B then mode pin A
// ----------------------------------------------------------------
`define OMD_MODE_BOOT 2'b00
`define OMD_MODE_TEST 2'b01
`define OMD_MODE_SINGLE 2'b10
`define OMD_MODE_EXP 2'b11

// ----------------------------------------------------------------
// Memory ranges and vectors
// ----------------------------------------------------------------
`define OMD_ROM_LO 16'he000
`define OMD_ROM_HI 16'hffff
`define OMD_BOOT_LO 16'hbf40
`define OMD_BOOT_HI 16'hbfff
`define OMD_EE_LO 16'hb600
`define OMD_EE_HI 16'hb7ff
`define OMD_VEC_USER 16'hfffe
`define OMD_VEC_BOOT 16'hbffe
`define OMD_RAM_PAGE_RESET 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OMD_INIT_WINDOW 7'h40

`endif

// ==== hw/omd_pkg.sv ====
// Types shared by the on-chip memory map decoder
package omd_pkg;

  // Secure bootstrap wipe sequencer
  typedef enum logic [2:0] {
    omd_wp_idle,
    omd_wp_erase,
    omd_wp_verify,
    omd_wp_cfg,
    omd_wp_done
  } omd_wipe_t;

  // Whole state of the decoder
  typedef struct packed {
    logic captured;
    logic [1:0] mode;
    logic secure;
    logic rom_on;
    logic ee_on;
    logic [6:0] win_cnt;
    logic [3:0] ram_page;
    logic boot_test_en;
    omd_wipe_t wipe;
    logic [7:0] cpu_rdata;
    logic sel_user_rom;
    logic sel_boot_rom;
    logic sel_ram;
    logic sel_eeprom;
    logic ext_bus_en;
    logic [15:0] vec_addr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic wipe_req;
    logic verify_req;
    logic cfg_erase_req;
    logic download_ok;
  } omd_state_t;

endpackage : omd_pkg

// ==== hw/omd_decode.sv ====
// On-chip memory map decoder with APB control registers
`timescale 1ns/1ps
`include "omd_params.svh"

module omd_decode
(
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps and nonvolatile configuration, caught after reset
  input wire logic [1:0] mode_pins,
  input wire logic user_rom_enable_cfg,
  input wire logic security_cfg,
  input wire logic eeprom_enable_cfg,
  // CPU side
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  output logic [7:0] cpu_rdata,
  output logic [15:0] reset_vector_addr,
  output logic [1:0] mode_out,
  // Memory selects and read data
  output logic sel_user_rom,
  output logic sel_boot_rom,
  output logic sel_ram,
  output logic sel_eeprom,
  input wire logic [7:0] user_rom_data,
  input wire logic [7:0] boot_rom_data,
  input wire logic [7:0] ram_data,
  input wire logic [7:0] eeprom_data,
  // External expansion bus
  output logic ext_bus_en,
  input wire logic [7:0] ext_data,
  // Secure bootstrap wipe handshake
  output logic wipe_req,
  input wire logic wipe_done,
  output logic verify_req,
  input wire logic verify_done,
  input wire logic verify_ok,
  output logic cfg_erase_req,
  input wire logic cfg_erase_done,
  output logic download_ok
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Inclusive address range test
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  omd_pkg::omd_state_t s; // Registered state
  omd_pkg::omd_state_t next_s; // Next state

  logic hit_ram; // Address in relocated RAM page
  logic hit_boot; // Address in mapped bootloader ROM
  logic hit_rom; // Address in enabled user ROM
  logic hit_ee; // Address in enabled EEPROM
  logic acc; // CPU access in progress
  logic win_open; // Mapping writes still allowed
  logic apb_do; // APB access acted on this edge, completes at the next

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Raw hits of each internal memory
  always_comb
  begin
    hit_ram = s.captured && (cpu_addr[15:12] == s.ram_page)
              && (cpu_addr[11:8] == 4'h0);
    hit_boot = s.captured
               && ((s.mode == `OMD_MODE_BOOT)
                   || ((s.mode == `OMD_MODE_TEST)
                       && s.boot_test_en))
               && in_range(cpu_addr, `OMD_BOOT_LO, `OMD_BOOT_HI);
    hit_rom = s.captured && s.rom_on
              && in_range(cpu_addr, `OMD_ROM_LO, `OMD_ROM_HI);
    hit_ee = s.captured && s.ee_on
             && in_range(cpu_addr, `OMD_EE_LO, `OMD_EE_HI);
    acc = cpu_rd || cpu_wr;
    win_open = (s.mode[1] == 1'b0) || (s.win_cnt < `OMD_INIT_WINDOW);
    apb_do = psel && penable && !s.pready;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  always_comb
  begin
    next_s = s;
    // Catch straps and configuration on the first edge after reset
    if (!s.captured)
    begin
      next_s.captured = 1'b1;
      next_s.secure = security_cfg;
      next_s.rom_on = user_rom_enable_cfg;
      next_s.ee_on = eeprom_enable_cfg;
      if (security_cfg)
        next_s.mode = {mode_pins[1], 1'b0};
      else
        next_s.mode = mode_pins;
      if (security_cfg && mode_pins[1])
        next_s.vec_addr = `OMD_VEC_USER;
      else if (!mode_pins[1] && (security_cfg || !mode_pins[0]))
        next_s.vec_addr = `OMD_VEC_BOOT;
      else
        next_s.vec_addr = `OMD_VEC_USER;
    end
    // Saturating count of cycles since reset
    if (s.captured && (s.win_cnt < `OMD_INIT_WINDOW))
      next_s.win_cnt = s.win_cnt + 7'h01;

    // Fixed priority: RAM, boot ROM, user ROM, EEPROM, bus
    next_s.sel_ram = 1'b0;
    next_s.sel_boot_rom = 1'b0;
    next_s.sel_user_rom = 1'b0;
    next_s.sel_eeprom = 1'b0;
    next_s.ext_bus_en = 1'b0;
    next_s.cpu_rdata = s.cpu_rdata;
    if (acc && hit_ram)
    begin
      next_s.sel_ram = 1'b1;
      next_s.cpu_rdata = ram_data;
    end
    else if (acc && hit_boot)
    begin
      next_s.sel_boot_rom = 1'b1;
      next_s.cpu_rdata = boot_rom_data;
    end
    else if (acc && hit_rom)
    begin
      next_s.sel_user_rom = 1'b1;
      next_s.cpu_rdata = user_rom_data;
    end
    else if (acc && hit_ee)
    begin
      next_s.sel_eeprom = 1'b1;
      next_s.cpu_rdata = eeprom_data;
    end
    else if (acc && s.captured && s.mode[0])
    begin
      // Only expanded and test modes own an external bus
      next_s.ext_bus_en = 1'b1;
      next_s.cpu_rdata = ext_data;
    end

    // Secure bootstrap wipe sequencer
    next_s.wipe_req = 1'b0;
    next_s.verify_req = 1'b0;
    next_s.cfg_erase_req = 1'b0;
    case (s.wipe)
      omd_pkg::omd_wp_idle:
      begin
        if (s.captured && (s.mode == `OMD_MODE_BOOT) && s.secure)
        begin
          next_s.wipe = omd_pkg::omd_wp_erase;
          next_s.wipe_req = 1'b1;
        end
        else if (s.captured && (s.mode == `OMD_MODE_BOOT))
          next_s.wipe = omd_pkg::omd_wp_done;
      end
      omd_pkg::omd_wp_erase:
      begin
        // Erase EEPROM and RAM first
        if (wipe_done)
        begin
          next_s.wipe = omd_pkg::omd_wp_verify;
          next_s.verify_req = 1'b1;
        end
        else
          next_s.wipe_req = 1'b1;
      end
      omd_pkg::omd_wp_verify:
      begin
        // Failed verify repeats the erase
        if (verify_done && verify_ok)
        begin
          next_s.wipe = omd_pkg::omd_wp_cfg;
          next_s.cfg_erase_req = 1'b1;
        end
        else if (verify_done)
        begin
          next_s.wipe = omd_pkg::omd_wp_erase;
          next_s.wipe_req = 1'b1;
        end
        else
          next_s.verify_req = 1'b1;
      end
      omd_pkg::omd_wp_cfg:
      begin
        // Config byte with the security bit goes last
        if (cfg_erase_done)
          next_s.wipe = omd_pkg::omd_wp_done;
        else
          next_s.cfg_erase_req = 1'b1;
      end
      default:
        next_s.wipe = omd_pkg::omd_wp_done;
    endcase
    next_s.download_ok = (next_s.wipe == omd_pkg::omd_wp_done);

    // APB slave, answers one cycle into the access phase
    next_s.pready = apb_do;
    next_s.pslverr = 1'b0;
    if (apb_do)
    begin
      next_s.prdata = 32'h0000_0000;
      if (paddr == `OMD_REG_CTRL)
      begin
        if (pwrite && win_open && s.captured)
        begin
          next_s.ram_page = pwdata[`OMD_CTRL_PAGE_MSB:0];
          next_s.boot_test_en = pwdata[`OMD_CTRL_BOOT_BIT];
        end
        next_s.prdata[`OMD_CTRL_PAGE_MSB:0] = s.ram_page;
        next_s.prdata[`OMD_CTRL_BOOT_BIT] = s.boot_test_en;
      end
      else if (paddr == `OMD_REG_STAT)
      begin
        next_s.prdata[`OMD_STAT_MODE_MSB:0] = s.mode;
        next_s.prdata[`OMD_STAT_SEC_BIT] = s.secure;
        next_s.prdata[`OMD_STAT_WIN_BIT] = win_open;
        next_s.prdata[`OMD_STAT_ROM_BIT] = s.rom_on;
        next_s.prdata[`OMD_STAT_DL_BIT] = s.download_ok;
      end
      else
        next_s.pslverr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // RAM page, window count and all outputs clear at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign cpu_rdata = s.cpu_rdata;
  assign reset_vector_addr = s.vec_addr;
  assign mode_out = s.mode;
  assign sel_user_rom = s.sel_user_rom;
  assign sel_boot_rom = s.sel_boot_rom;
  assign sel_ram = s.sel_ram;
  assign sel_eeprom = s.sel_eeprom;
  assign ext_bus_en = s.ext_bus_en;
  assign wipe_req = s.wipe_req;
  assign verify_req = s.verify_req;
  assign cfg_erase_req = s.cfg_erase_req;
  assign download_ok = s.download_ok;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rom_off;
    s.captured && !s.rom_on && acc |=> !sel_user_rom;
  endproperty
  a_rom_off: assert property (p_rom_off)
    else $error("disabled user ROM was selected");

  property p_boot_normal;
    s.mode[1] |=> !sel_boot_rom;
  endproperty
  a_boot_normal: assert property (p_boot_normal)
    else $error("bootloader ROM selected in a normal mode");

  property p_boot_test;
    (s.mode == `OMD_MODE_TEST) && !s.boot_test_en |=> !sel_boot_rom;
  endproperty
  a_boot_test: assert property (p_boot_test)
    else $error("bootloader ROM selected before test enable");

  property p_boot_map;
    s.captured && (s.mode == `OMD_MODE_BOOT) && cpu_rd
      && (cpu_addr == `OMD_VEC_BOOT) && !hit_ram
      |=> sel_boot_rom && (reset_vector_addr == `OMD_VEC_BOOT);
  endproperty
  a_boot_map: assert property (p_boot_map)
    else $error("bootstrap vector not served by bootloader ROM");

  property p_secure_mode;
    s.captured && s.secure |-> !mode_out[0];
  endproperty
  a_secure_mode: assert property (p_secure_mode)
    else $error("secured part left in expanded or test mode");

  property p_single_nobus;
    !s.mode[0] |=> !ext_bus_en;
  endproperty
  a_single_nobus: assert property (p_single_nobus)
    else $error("external bus active in single-chip mode");

  property p_wipe_order;
    s.secure && $rose(download_ok) |-> $past(cfg_erase_done);
  endproperty
  a_wipe_order: assert property (p_wipe_order)
    else $error("download allowed before config erase");

  property p_ram_page;
    s.captured && acc && (cpu_addr[15:12] == s.ram_page)
      && (cpu_addr[11:8] == 4'h0) |=> sel_ram;
  endproperty
  a_ram_page: assert property (p_ram_page)
    else $error("relocated RAM page not selected");

  property p_win_lock;
    s.mode[1] && (s.win_cnt == `OMD_INIT_WINDOW) |=> $stable(s.ram_page);
  endproperty
  a_win_lock: assert property (p_win_lock)
    else $error("RAM page changed after the write window");

  property p_int_data;
    sel_ram |-> cpu_rdata == $past(ram_data);
  endproperty
  a_int_data: assert property (p_int_data)
    else $error("RAM hit did not return RAM data");

  property p_one_src;
    $onehot0({sel_ram, sel_boot_rom, sel_user_rom, sel_eeprom,
              ext_bus_en});
  endproperty
  a_one_src: assert property (p_one_src)
    else $error("more than one read source selected");

  c_wipe_done: cover property (s.secure && $rose(download_ok));
  c_wipe_retry: cover property (verify_done && !verify_ok ##1 wipe_req);
  c_ram_moved: cover property (sel_ram && (s.ram_page != 4'h0));
  c_boot_test: cover property ((s.mode == `OMD_MODE_TEST) && sel_boot_rom);

endmodule : omd_decode

// ==== verification/omd_mem_model.sv ====
// Memory arrays, external bus and wipe responder facing the decoder
`timescale 1ns/1ps
module omd_mem_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic [15:0] cpu_addr,
  input wire logic wipe_req,
  input wire logic verify_req,
  input wire logic cfg_erase_req,
  output logic [7:0] user_rom_data,
  output logic [7:0] boot_rom_data,
  output logic [7:0] ram_data,
  output logic [7:0] eeprom_data,
  output logic [7:0] ext_data,
  output logic wipe_done,
  output logic verify_done,
  output logic verify_ok,
  output logic cfg_erase_done
);
  logic [3:0] cnt; // Cycles spent on the pending request
  logic busy; // Some wipe step requested
  logic fin; // Pending step has taken lat cycles
  logic vseen; // A verify has answered since reset
  // Each array gives its own pattern, so a wrong pick shows
  assign user_rom_data = cpu_addr[7:0] ^ 8'h5a;
  assign boot_rom_data = cpu_addr[7:0] ^ 8'ha5; // Own array
  assign ram_data = cpu_addr[7:0] ^ 8'h3c;
  assign eeprom_data = cpu_addr[7:0] ^ 8'hc3; // Own array
  // Bus data differs from any internal array
  assign ext_data = cpu_addr[7:0] ^ 8'hf0;
  // Each step answers after lat cycles
  assign busy = wipe_req | verify_req | cfg_erase_req;
  assign fin = busy && cnt >= lat;
  assign wipe_done = fin && wipe_req;
  assign verify_done = fin && verify_req;
  // First verify after reset fails, so the erase retry path runs
  assign verify_ok = vseen;
  assign cfg_erase_done = fin && cfg_erase_req;
  // Latency counter restarts for every request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 4'h0;
    else if (busy && !fin)
      cnt <= cnt + 4'h1;
    else
      cnt <= 4'h0;
  end
  // Remember that one verify has already answered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vseen <= 1'b0;
    else if (verify_done)
      vseen <= 1'b1;
  end
endmodule : omd_mem_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the on-chip memory map decoder
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  localparam logic [4:0] SU = 5'h10, SB = 5'h08, SR = 5'h04;
  localparam logic [4:0] SE = 5'h02, SX = 5'h01, SN = 5'h00;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cpu_rd = 1'b0, cpu_wr = 1'b0;
  logic [1:0] mode_pins = 2'b10, mode_out;
  logic user_rom_enable_cfg = 1'b1, security_cfg = 1'b0;
  logic eeprom_enable_cfg = 1'b1;
  logic [15:0] cpu_addr = 16'h0, reset_vector_addr;
  logic [7:0] cpu_rdata, user_rom_data, boot_rom_data, ram_data;
  logic [7:0] eeprom_data, ext_data;
  logic sel_user_rom, sel_boot_rom, sel_ram, sel_eeprom, ext_bus_en;
  logic wipe_req, wipe_done, verify_req, verify_done, verify_ok;
  logic cfg_erase_req, cfg_erase_done, download_ok;
  logic [3:0] lat = 4'h5; // Partner answer latency
  int miscompares = 0;
  int compares = 0;
  logic [13:0] cq[$]; // Notes: check data, sources, data
  logic [33:0] aq[$]; // Notes: check data, error, read data
  logic [13:0] c;
  logic [33:0] b;
  logic rd_d = 1'b0; // CPU access sampled at last edge
  logic sw, sv, sc, bad; // Wipe steps seen, and order broken
  logic [4:0] sels; // Selects seen, packed like the source codes
  assign sels = {sel_user_rom, sel_boot_rom, sel_ram, sel_eeprom,
                 ext_bus_en};

  always #5 pclk = ~pclk;

  omd_decode i_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mode_pins, .user_rom_enable_cfg,
    .security_cfg, .eeprom_enable_cfg, .cpu_addr, .cpu_rd, .cpu_wr,
    .cpu_rdata, .reset_vector_addr, .mode_out, .sel_user_rom,
    .sel_boot_rom, .sel_ram, .sel_eeprom, .user_rom_data,
    .boot_rom_data, .ram_data, .eeprom_data, .ext_bus_en, .ext_data,
    .wipe_req, .wipe_done, .verify_req, .verify_done, .verify_ok,
    .cfg_erase_req, .cfg_erase_done, .download_ok
  );
  omd_mem_model i_mem
  (
    .pclk, .presetn, .lat, .cpu_addr, .user_rom_data, .boot_rom_data,
    .ram_data, .eeprom_data, .ext_data, .wipe_req, .wipe_done,
    .verify_req, .verify_done, .verify_ok, .cfg_erase_req,
    .cfg_erase_done
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Data each source gives for an address
  function automatic logic [7:0] dat(input logic [4:0] s,
                                     input logic [7:0] a);
    case (s)
      SU: return a ^ 8'h5a;
      SB: return a ^ 8'ha5;
      SR: return a ^ 8'h3c;
      SE: return a ^ 8'hc3;
      default: return a ^ 8'hf0;
    endcase
  endfunction : dat

  // Reset with straps, then let capture and first access edge pass
  task automatic rst(input logic [1:0] m, input logic rom, sec);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_pins <= m;
    user_rom_enable_cfg <= rom;
    eeprom_enable_cfg <= rom;
    security_cfg <= sec;
    lat <= 4'($urandom_range(9, 2));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : rst

  // One CPU access, a write if w; expected source and data queued
  task automatic rd(input logic [15:0] a, input logic [4:0] s,
                    input logic w = 1'b0);
    @(posedge pclk);
    cpu_addr <= a;
    cpu_rd <= !w;
    cpu_wr <= w;
    cq.push_back({s != SN && !w, s, dat(s, a[7:0])});
    @(posedge pclk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
  endtask : rd

  // APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    aq.push_back({!w && !err, err, d});
    @(posedge pclk);
    penable <= 1'b1;
    // No timeout here; only the watchdog ends a wait that never gets pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  always @(posedge pclk)
    rd_d <= cpu_rd | cpu_wr;

  // Oldest note against each answer at the outputs
  always @(negedge pclk)
  begin
    if (rd_d)
    begin
      c = cq.pop_front();
      check("sel", 32'(sels), 32'(c[12:8]));
      if (c[13])
        check("cpu_rdata", 32'(cpu_rdata), 32'(c[7:0]));
    end
    if (pready === 1'b1)
    begin
      b = aq.pop_front();
      check("pslverr", 32'(pslverr), 32'(b[32]));
      if (b[33])
        check("prdata", prdata, b[31:0]);
    end
  end

  // Track order of the wipe steps
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {sw, sv, sc, bad} <= 4'h0;
    else
    begin
      sw <= sw | wipe_req;
      sv <= sv | verify_req;
      sc <= sc | cfg_erase_req;
      if ((verify_req && !sw) || (cfg_erase_req && !sv) ||
          (download_ok && !sc))
        bad <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(3491));
    rst(2'b10, 1'b1, 1'b0);
    check("vector", 32'(reset_vector_addr), 32'hfffe); // User
    rd(16'hfffe, SU); // ROM, no bus
    rd({8'h00, 8'($urandom)}, SR); // Page 0
    rd(16'hbffe, SN); // No boot ROM
    rd(16'hb600, SE); // EEPROM
    rd(16'hb7ff, SE, 1'b1); // EEPROM write
    apb(1'b0, 12'h004, 32'h1a, 1'b0); // Window open
    apb(1'b1, 12'h000, 32'h5, 1'b0); // Move RAM
    rd({8'h50, 8'($urandom)}, SR); // Page 5
    repeat (70) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h3, 1'b0); // Late write
    rd({8'h50, 8'($urandom)}, SR); // Unmoved
    apb(1'b0, 12'h004, 32'h12, 1'b0); // Closed
    apb(1'b0, 12'h008, 32'h0, 1'b1); // Unmapped
    rst(2'b11, 1'b0, 1'b0);
    rd(16'he000, SX); // No ROM
    rd(16'hfffe, SX); // Bit clear
    rd(16'hbf40, SX); // Boot off
    rd(16'hb600, SX); // EEPROM off
    rst(2'b11, 1'b1, 1'b0);
    rd(16'hfffe, SU); // Internal wins
    rst(2'b01, 1'b1, 1'b0);
    rd(16'hbfc0, SX); // Boot absent
    apb(1'b1, 12'h000, 32'h10, 1'b0); // Enable
    rd(16'hbfc0, SB); // Present
    apb(1'b1, 12'h000, 32'h1e, 1'b0); // RAM over ROM
    rd(16'he010, SR); // RAM first
    rd(16'he100, SU); // ROM beyond RAM
    rst(2'b00, 1'b1, 1'b0);
    check("vector", 32'(reset_vector_addr), 32'hbffe); // Boot
    rd(16'hbffe, SB); // Vector bytes
    rd(16'hbf40, SB); // Base
    check("download", 32'(download_ok), 32'h1); // Unsecured
    for (int m = 0; m < 4; m++)
    begin
      rst(2'(m), 1'b1, 1'b1);
      check("mode", 32'(mode_out), 32'(m & 2)); // Forced
      if (m > 1)
        rd(16'h4000, SN); // No bus
      for (int i = 0; i < 60 && download_ok !== 1'b1; i++)
        @(posedge pclk);
      check("download", 32'(download_ok), 32'(m < 2));
      check("order", 32'(bad), 32'h0); // Step order
    end
    results();
  end

  // Cut a hang short
  initial
  begin
    #100000;
    miscompares++;
    results();
  end
endmodule : tb_top
